// File: include/rca_pkg.sv
// package of constants and types for the radio channel access timing block
package rca_pkg;
  // clock 25 MHz, timing tick 10 ms
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned TICK_MS       = 10;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICKS_PER_SEC = 1000 / TICK_MS;

  // register byte addresses
  localparam logic [7:0] ADDR_CLEAR_WAIT = 8'h00;
  localparam logic [7:0] ADDR_SLOT       = 8'h04;
  localparam logic [7:0] ADDR_PERSISTENCE_THRESHOLD    = 8'h08;
  localparam logic [7:0] ADDR_KEYUP      = 8'h0C;
  localparam logic [7:0] ADDR_ACKWAIT    = 8'h10;
  localparam logic [7:0] ADDR_RETRY      = 8'h14;
  localparam logic [7:0] ADDR_CONTROL    = 8'h18;
  localparam logic [7:0] ADDR_STATUS     = 8'h1C;
  localparam logic [7:0] ADDR_TXDATA     = 8'h20;

  // reset values
  localparam logic [7:0] RST_CLEAR_WAIT = 8'h00;
  localparam logic [7:0] RST_SLOT       = 8'h0A;
  localparam logic [7:0] RST_PERSISTENCE_THRESHOLD    = 8'h3F;
  localparam logic [7:0] RST_KEYUP      = 8'h1E;
  localparam logic [7:0] RST_ACKWAIT    = 8'h04;
  localparam logic [7:0] RST_RETRY      = 8'h0A;
  localparam logic [7:0] LFSR_SEED      = 8'hA5;

  // control register fields
  localparam int unsigned CTL_LINKV2   = 0;
  localparam int unsigned CTL_DIGI     = 1;
  localparam int unsigned CTL_NEEDACK  = 2;
  localparam int unsigned CTL_START    = 3;
  localparam int unsigned CTL_ACKRX    = 4;
  localparam int unsigned CTL_DIGN_LSB = 8;

  localparam logic [7:0] HDLC_FLAG = 8'h7E;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_CLEAR   = 4'b0001,
    ST_SLOT    = 4'b0010,
    ST_DRAW    = 4'b0011,
    ST_KEYUP   = 4'b0100,
    ST_DATA    = 4'b0101,
    ST_CLOSE   = 4'b0110,
    ST_ACKWAIT = 4'b0111,
    ST_DISC    = 4'b1000
  } rca_state_t;

  typedef enum logic [1:0] {
    FR_DATA = 2'b00,
    FR_POLL = 2'b01,
    FR_DISC = 2'b10
  } rca_frame_t;
endpackage

// File: hw/rca_skid.sv
// two-entry valid/ready buffer for the transmit octet stream
`timescale 1ns/100ps
module rca_skid (
  input  wire logic       clk,      // clock
  input  wire logic       rst_b,    // async reset, active low
  input  wire logic [7:0] inData,   // octet in
  input  wire logic       inValid,  // octet offered
  output logic            inReady,  // room for an octet
  output logic [7:0]      outData,  // octet out
  output logic            outValid, // octet available
  input  wire logic       outReady  // consumer takes octet
);
  logic [7:0] mem [2];
  logic       wrPtr;
  logic       rdPtr;
  logic [1:0] count;
  logic       push;
  logic       pop;

  // a full buffer still takes a word in the cycle it hands one out
  assign inReady  = (count != 2'h2) || outReady;
  assign outValid = (count != 2'h0);
  assign outData  = mem[rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wrPtr <= ~wrPtr;
      end
      if (pop) begin
        rdPtr <= ~rdPtr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// File: hw/rca_channel_access.sv
// transmit channel access, key-up, ack timer and retry sequencing
//
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
module rca_channel_access (
  input  wire logic        clk,          // clock, 25 MHz
  input  wire logic        rst_b,        // async reset, active low
  input  wire logic [31:0] haddr,        // ahb address
  input  wire logic [1:0]  htrans,       // ahb transfer type
  input  wire logic        hwrite,       // ahb write
  input  wire logic [2:0]  hsize,        // ahb size
  input  wire logic [31:0] hwdata,       // ahb write data
  input  wire logic        hsel,         // ahb slave select
  input  wire logic        hready,       // ahb bus ready
  output logic [31:0]      hrdata,       // ahb read data
  output logic             hreadyout,    // ahb slave ready
  output logic             hresp,        // ahb response, always okay
  input  wire logic        carrierDetect,// carrier from radio
  output logic             transmitKey,  // push-to-talk to radio
  output logic [7:0]       txOctet,      // octet to modulator
  output logic             txValid,      // octet valid
  input  wire logic        txReady,      // modulator takes octet
  output logic [1:0]       txKind,       // frame kind being sent
  output logic             txFrameBody   // octet is frame content
);
  logic [7:0]  clearWait;
  logic [7:0]  slotTime;
  logic [7:0]  persistenceThreshold;
  logic [7:0]  keyupFlagDelay;
  logic [7:0]  ackWaitTime;
  logic [7:0]  retryLimit;
  logic        linkVersionSelect;
  logic        digiFrame;
  logic        needAck;
  logic [3:0]  digiCount;
  rca_pkg::rca_state_t state;
  rca_pkg::rca_frame_t frameKind;
  logic [23:0] tickCnt;
  logic        tick;
  logic [15:0] waitTicks;
  logic [19:0] ackTicks;
  logic [19:0] ackTarget;
  logic [7:0]  tries;
  logic [7:0]  lfsr;
  logic        discarded;
  logic        connected;
  logic        startReq;
  logic        ackReq;
  logic        wrPend;
  logic [7:0]  wrAddr;
  logic [7:0]  rdAddr;
  logic        wrData;
  logic [7:0]  fifoData;
  logic        fifoValid;
  logic        fifoReady;
  logic        fifoInReady;
  logic        txLoad;
  logic        bodyLoad;
  logic        popBody;
  logic        recirc;
  logic        hostPush;
  logic        retire;
  logic        flushing;
  logic [1:0]  bodyLen;
  logic [1:0]  bodySent;
  logic [7:0]  next_lfsr;

  // registers answer in zero wait states
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
    end else begin
      wrPend <= hsel && hready && htrans[1] && hwrite;
      wrAddr <= haddr[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdAddr <= 8'h00;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      rdAddr <= haddr[7:0];
    end
  end

  always_comb begin
    unique case (rdAddr)
      rca_pkg::ADDR_CLEAR_WAIT: hrdata = {24'h000000, clearWait};
      rca_pkg::ADDR_SLOT:       hrdata = {24'h000000, slotTime};
      rca_pkg::ADDR_PERSISTENCE_THRESHOLD:    hrdata = {24'h000000, persistenceThreshold};
      rca_pkg::ADDR_KEYUP:      hrdata = {24'h000000, keyupFlagDelay};
      rca_pkg::ADDR_ACKWAIT:    hrdata = {24'h000000, ackWaitTime};
      rca_pkg::ADDR_RETRY:      hrdata = {24'h000000, retryLimit};
      rca_pkg::ADDR_CONTROL:    hrdata = {20'h00000, digiCount, 5'h00, needAck, digiFrame,
                                          linkVersionSelect};
      rca_pkg::ADDR_STATUS:     hrdata = {8'h00, tries, 6'h00, frameKind, fifoInReady,
                                          discarded, connected, transmitKey, state};
      default:                  hrdata = 32'h00000000;
    endcase
  end

  // configuration writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clearWait            <= rca_pkg::RST_CLEAR_WAIT;
      slotTime             <= rca_pkg::RST_SLOT;
      persistenceThreshold <= rca_pkg::RST_PERSISTENCE_THRESHOLD;
      keyupFlagDelay       <= rca_pkg::RST_KEYUP;
      ackWaitTime          <= rca_pkg::RST_ACKWAIT;
      retryLimit           <= rca_pkg::RST_RETRY;
      linkVersionSelect    <= 1'b0;
      digiFrame            <= 1'b0;
      needAck              <= 1'b0;
      digiCount            <= 4'h0;
    end else if (wrPend) begin
      unique case (wrAddr)
        rca_pkg::ADDR_CLEAR_WAIT: clearWait            <= hwdata[7:0];
        rca_pkg::ADDR_SLOT:       slotTime             <= hwdata[7:0];
        rca_pkg::ADDR_PERSISTENCE_THRESHOLD:    persistenceThreshold <= hwdata[7:0];
        rca_pkg::ADDR_KEYUP:      keyupFlagDelay       <= hwdata[7:0];
        rca_pkg::ADDR_ACKWAIT:    ackWaitTime          <= hwdata[7:0];
        rca_pkg::ADDR_RETRY:      retryLimit           <= hwdata[7:0];
        rca_pkg::ADDR_CONTROL: begin
          linkVersionSelect <= hwdata[rca_pkg::CTL_LINKV2];
          digiFrame         <= hwdata[rca_pkg::CTL_DIGI];
          needAck           <= hwdata[rca_pkg::CTL_NEEDACK];
          digiCount         <= hwdata[rca_pkg::CTL_DIGN_LSB +: 4];
        end
        default: ;
      endcase
    end
  end

  // start and ack strobes; a start write is held until the fsm takes it in idle, an ack write lasts one cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      startReq <= 1'b0;
      ackReq   <= 1'b0;
    end else begin
      if (wrPend && wrAddr == rca_pkg::ADDR_CONTROL && hwdata[rca_pkg::CTL_START]) begin
        startReq <= 1'b1;
      end else if (state == rca_pkg::ST_IDLE) begin
        startReq <= 1'b0;
      end
      if (wrPend && wrAddr == rca_pkg::ADDR_CONTROL && hwdata[rca_pkg::CTL_ACKRX]) begin
        ackReq <= 1'b1;
      end else if (state != rca_pkg::ST_ACKWAIT) begin
        ackReq <= 1'b0;
      end else begin
        ackReq <= 1'b0;
      end
    end
  end

  // frame octets: bits 7:0 of the write are the octet; bit 8 is not used
  assign wrData = wrPend && (wrAddr == rca_pkg::ADDR_TXDATA);

  rca_skid u_skid (
    .clk      (clk),
    .rst_b    (rst_b),
    .inData   (recirc ? fifoData : hwdata[7:0]),
    .inValid  (wrData || recirc),
    .inReady  (fifoInReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoReady)
  );

  // frame length counts host octets; a host write in a cycle that recirculates an acked octet is lost
  assign hostPush = wrData && !recirc && fifoInReady;
  assign retire   = (state == rca_pkg::ST_CLOSE && txReady && !needAck &&
                     frameKind == rca_pkg::FR_DATA) ||
                    (state == rca_pkg::ST_ACKWAIT && ackReq) ||
                    (state == rca_pkg::ST_ACKWAIT && ackTicks >= ackTarget &&
                     tries >= retryLimit && frameKind == rca_pkg::FR_DISC);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bodyLen <= 2'h0;
    end else if (retire) begin
      bodyLen <= {1'b0, hostPush};
    end else if (hostPush) begin
      bodyLen <= bodyLen + 2'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bodySent <= 2'h0;
    end else if (state == rca_pkg::ST_KEYUP) begin
      bodySent <= 2'h0;
    end else if (popBody) begin
      bodySent <= bodySent + 2'h1;
    end
  end
  // a retired acked frame is drained so the next one starts clean
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flushing <= 1'b0;
    end else if (retire && needAck) begin
      flushing <= 1'b1;
    end else if (!fifoValid) begin
      flushing <= 1'b0;
    end
  end

  // 10 ms tick
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tickCnt <= 24'h000000;
    end else if (tickCnt == 24'(rca_pkg::TICK_CYCLES - 1)) begin
      tickCnt <= 24'h000000;
    end else begin
      tickCnt <= tickCnt + 24'h000001;
    end
  end
  assign tick = (tickCnt == 24'(rca_pkg::TICK_CYCLES - 1));

  // random source for the persistence draw, 1..255
  assign next_lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lfsr <= rca_pkg::LFSR_SEED;
    end else begin
      lfsr <= next_lfsr;
    end
  end

  // ack wait in ticks: seconds times (2n+1)
  assign ackTarget = 20'(ackWaitTime * rca_pkg::TICKS_PER_SEC * ({digiCount, 1'b1}));

  // main sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= rca_pkg::ST_IDLE;
      waitTicks <= 16'h0000;
      ackTicks  <= 20'h00000;
      tries     <= 8'h00;
      frameKind <= rca_pkg::FR_DATA;
      discarded <= 1'b0;
      connected <= 1'b0;
    end else begin
      unique case (state)
        rca_pkg::ST_IDLE: begin
          waitTicks <= 16'h0000;
          if (startReq) begin
            frameKind <= rca_pkg::FR_DATA;
            tries     <= 8'h00;
            discarded <= 1'b0;
            connected <= 1'b1;
            state     <= rca_pkg::ST_CLEAR;
          end
        end
        rca_pkg::ST_CLEAR: begin
          if (carrierDetect) begin
            waitTicks <= 16'h0000;
          end else if (digiFrame) begin
            waitTicks <= 16'h0000;
            state     <= rca_pkg::ST_KEYUP;
          end else if (waitTicks >= {8'h00, clearWait}) begin
            waitTicks <= 16'h0000;
            state     <= rca_pkg::ST_SLOT;
          end else if (tick) begin
            waitTicks <= waitTicks + 16'h0001;
          end
        end
        rca_pkg::ST_SLOT: begin
          if (carrierDetect) begin
            waitTicks <= 16'h0000;
          end else if (waitTicks >= {8'h00, slotTime}) begin
            state <= rca_pkg::ST_DRAW;
          end else if (tick) begin
            waitTicks <= waitTicks + 16'h0001;
          end
        end
        rca_pkg::ST_DRAW: begin
          waitTicks <= 16'h0000;
          if (carrierDetect) begin
            state <= rca_pkg::ST_SLOT;
          end else if (lfsr < persistenceThreshold) begin
            state <= rca_pkg::ST_KEYUP;
          end else begin
            state <= rca_pkg::ST_SLOT;
          end
        end
        rca_pkg::ST_KEYUP: begin
          if (txLoad && waitTicks >= {8'h00, keyupFlagDelay}) begin
            waitTicks <= 16'h0000;
            state     <= rca_pkg::ST_DATA;
          end else if (tick) begin
            waitTicks <= waitTicks + 16'h0001;
          end
        end
        rca_pkg::ST_DATA: begin
          if (txLoad && (frameKind != rca_pkg::FR_DATA || bodySent == bodyLen)) begin
            state <= rca_pkg::ST_CLOSE;
          end
        end
        rca_pkg::ST_CLOSE: begin
          if (txReady) begin
            ackTicks <= 20'h00000;
            state    <= (needAck || frameKind != rca_pkg::FR_DATA) ?
                        rca_pkg::ST_ACKWAIT : rca_pkg::ST_IDLE;
          end
        end
        rca_pkg::ST_ACKWAIT: begin
          if (ackReq) begin
            state <= rca_pkg::ST_IDLE;
            if (frameKind == rca_pkg::FR_DISC) begin
              connected <= 1'b0;
            end
          end else if (ackTicks >= ackTarget) begin
            if (tries < retryLimit) begin
              tries <= tries + 8'h01;
              if (frameKind == rca_pkg::FR_DATA && linkVersionSelect) begin
                frameKind <= rca_pkg::FR_POLL;
              end
              state <= rca_pkg::ST_CLEAR;
            end else if (frameKind != rca_pkg::FR_DISC) begin
              tries     <= 8'h00;
              frameKind <= rca_pkg::FR_DISC;
              state     <= rca_pkg::ST_CLEAR;
            end else begin
              discarded <= 1'b1;
              connected <= 1'b0;
              state     <= rca_pkg::ST_DISC;
            end
          end else if (tick && !carrierDetect) begin
            ackTicks <= ackTicks + 20'h00001;
          end
        end
        rca_pkg::ST_DISC: begin
          state <= rca_pkg::ST_IDLE;
        end
        default: state <= rca_pkg::ST_IDLE;
      endcase
    end
  end

  // output stage loads only when empty or its octet is taken
  assign txLoad    = !txValid || txReady;
  assign bodyLoad  = (state == rca_pkg::ST_DATA) && (frameKind == rca_pkg::FR_DATA) &&
                     (bodySent != bodyLen) && fifoValid;
  assign popBody   = bodyLoad && txLoad;
  // acked frames go back to the tail so a resend is whole
  assign recirc    = popBody && needAck;
  assign fifoReady = popBody || flushing;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      transmitKey <= 1'b0;
      txOctet     <= 8'h00;
      txValid     <= 1'b0;
      txFrameBody <= 1'b0;
      txKind      <= 2'h0;
    end else begin
      transmitKey <= (state == rca_pkg::ST_KEYUP) || (state == rca_pkg::ST_DATA) ||
                     (state == rca_pkg::ST_CLOSE && !txReady);
      if (txLoad) begin
        txValid     <= (state == rca_pkg::ST_KEYUP) || (state == rca_pkg::ST_DATA);
        txKind      <= frameKind;
        txFrameBody <= bodyLoad;
        txOctet     <= bodyLoad ? fifoData : rca_pkg::HDLC_FLAG;
      end
    end
  end
endmodule

// File: bench/rca_props.sv
// concurrent checks on the radio side of the channel access block
`timescale 1ns/100ps
module rca_props (
  input wire logic       clk,           // clock
  input wire logic       rst_b,         // async reset, active low
  input wire logic       carrierDetect, // carrier from radio
  input wire logic       transmitKey,   // push-to-talk
  input wire logic [7:0] txOctet,       // octet to modulator
  input wire logic       txValid,       // octet valid
  input wire logic       txReady,       // modulator takes octet
  input wire logic [1:0] txKind,        // frame kind
  input wire logic       txFrameBody    // octet is content
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_busy;
    carrierDetect [*4];
  endsequence
  sequence s_stall;
    txValid && !txReady;
  endsequence

  a_body_keyed: assert property (txFrameBody |-> transmitKey)
    else $error("frame content sent without key");
  a_valid_keyed: assert property (txValid |-> transmitKey)
    else $error("octet offered without key");
  a_flag_fill: assert property (txValid && !txFrameBody |-> txOctet == rca_pkg::HDLC_FLAG)
    else $error("non-content octet is not a flag");
  a_busy_nokey: assert property (s_busy |=> !$rose(transmitKey))
    else $error("key raised on a busy channel");
  a_stall_hold: assert property (s_stall |=> txValid && $stable(txOctet) && $stable(txFrameBody))
    else $error("octet changed while stalled");
  a_kind_steady: assert property (txFrameBody && $past(txFrameBody) |-> $stable(txKind))
    else $error("frame kind changed inside a frame");
  a_key_flags_first: assert property ($rose(transmitKey) |-> !txFrameBody)
    else $error("content at key-up");
  a_key_closes_flag: assert property ($fell(transmitKey) |-> !$past(txFrameBody))
    else $error("key dropped before closing flag");
  a_kind_known: assert property (txFrameBody |-> txKind != 2'b11)
    else $error("unknown frame kind");
endmodule

// File: bench/rca_radio_model.sv
// radio transceiver model: carrier level and octet acceptance
`timescale 1ns/100ps
module rca_radio_model (
  input  wire logic clk,           // clock
  input  wire logic rst_b,         // async reset, active low
  input  wire logic busy,          // other stations on air
  input  wire logic slow,          // stall every other cycle
  input  wire logic transmitKey,   // push-to-talk
  output logic      carrierDetect, // carrier to block
  output logic      txReady        // octet taken
);
  logic phase;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) phase <= 1'b0;
    else phase <= ~phase;
  end

  assign carrierDetect = busy;
  // an unkeyed modulator takes nothing
  assign txReady = transmitKey && (!slow || phase);
endmodule

// File: bench/rca_channel_access_tb_top.sv
// top testbench of the channel access block
`timescale 1ns/100ps
module rca_channel_access_tb_top;
  logic        clk, rst_b, hwrite, hsel, busy, slow;
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire  logic [31:0] hrdata;
  wire  logic hreadyout, hresp, carrierDetect, transmitKey, txValid, txReady, txFrameBody;
  wire  logic [7:0] txOctet;
  wire  logic [1:0] txKind;
  int          errors, compares;
  logic [7:0]  got[$];

  rca_channel_access dut (.clk(clk), .rst_b(rst_b), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .carrierDetect(carrierDetect),
    .transmitKey(transmitKey), .txOctet(txOctet), .txValid(txValid), .txReady(txReady),
    .txKind(txKind), .txFrameBody(txFrameBody));

  rca_radio_model radio (.clk(clk), .rst_b(rst_b), .busy(busy), .slow(slow),
    .transmitKey(transmitKey), .carrierDetect(carrierDetect), .txReady(txReady));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'b010;
    htrans <= 2'b10;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    check(x, e);
  endtask

  // key must stay down for the whole span
  task automatic quiet(input int cycles);
    logic k;
    k = 1'b0;
    repeat (cycles) begin
      @(posedge clk);
      if (transmitKey !== 1'b0) k = 1'b1;
    end
    check({31'h0, k}, 32'h0);
  endtask

  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input int lim);
    int n;
    n = 0;
    got.delete();
    while (transmitKey !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    check({31'h0, n < lim}, 32'h1);
    n = 0;
    while (transmitKey === 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
      if (txValid === 1'b1 && txReady === 1'b1 && txFrameBody === 1'b1) begin
        got.push_back(txOctet);
        check({30'h0, txKind}, {30'h0, rca_pkg::FR_DATA});
      end
    end
    check(got.size(), 32'h2);
    check({24'h0, got[0]}, {24'h0, b0});
    check({24'h0, got[1]}, {24'h0, b1});
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    wrap_up();
  end

  initial begin
    errors = 0;
    compares = 0;
    rst_b = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    busy = 1'b0;
    slow = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    hsel <= 1'b1;
    @(posedge clk);
    rdc(rca_pkg::ADDR_CLEAR_WAIT, {24'h0, rca_pkg::RST_CLEAR_WAIT});
    rdc(rca_pkg::ADDR_SLOT, {24'h0, rca_pkg::RST_SLOT});
    rdc(rca_pkg::ADDR_PERSISTENCE_THRESHOLD, {24'h0, rca_pkg::RST_PERSISTENCE_THRESHOLD});
    rdc(rca_pkg::ADDR_KEYUP, {24'h0, rca_pkg::RST_KEYUP});
    rdc(rca_pkg::ADDR_ACKWAIT, {24'h0, rca_pkg::RST_ACKWAIT});
    rdc(rca_pkg::ADDR_RETRY, {24'h0, rca_pkg::RST_RETRY});
    rdc(8'h40, 32'h0);
    // short settings: one tick is far too long for a bench run
    wr(rca_pkg::ADDR_SLOT, 32'h0);
    wr(rca_pkg::ADDR_KEYUP, 32'h0);
    wr(rca_pkg::ADDR_PERSISTENCE_THRESHOLD, 32'h0);
    rdc(rca_pkg::ADDR_SLOT, 32'h0);
    // threshold zero: no draw can be below it
    wr(rca_pkg::ADDR_TXDATA, 32'h11);
    wr(rca_pkg::ADDR_TXDATA, 32'h122);
    wr(rca_pkg::ADDR_CONTROL, 32'h8);
    quiet(2000);
    busy <= 1'b1;
    wr(rca_pkg::ADDR_PERSISTENCE_THRESHOLD, 32'hFF);
    quiet(300);
    slow <= 1'b1;
    busy <= 1'b0;
    frame(8'h11, 8'h22, 3000);
    // relayed frame ignores a zero threshold, waits only for carrier
    wr(rca_pkg::ADDR_PERSISTENCE_THRESHOLD, 32'h0);
    busy <= 1'b1;
    wr(rca_pkg::ADDR_TXDATA, 32'h33);
    wr(rca_pkg::ADDR_TXDATA, 32'h144);
    wr(rca_pkg::ADDR_CONTROL, 32'hA);
    quiet(300);
    busy <= 1'b0;
    frame(8'h33, 8'h44, 12);
    // zero ack wait, one retry: resend, then disconnect twice, then discard
    wr(rca_pkg::ADDR_ACKWAIT, 32'h0);
    wr(rca_pkg::ADDR_RETRY, 32'h1);
    wr(rca_pkg::ADDR_PERSISTENCE_THRESHOLD, 32'hFF);
    wr(rca_pkg::ADDR_TXDATA, 32'h55);
    wr(rca_pkg::ADDR_TXDATA, 32'h166);
    wr(rca_pkg::ADDR_CONTROL, 32'hC);
    frame(8'h55, 8'h66, 3000);
    frame(8'h55, 8'h66, 3000);
    repeat (1500) @(posedge clk);
    rdc(rca_pkg::ADDR_STATUS, 32'h000102C0);
    wrap_up();
  end
endmodule

bind rca_channel_access rca_props u_props (.clk(clk), .rst_b(rst_b),
  .carrierDetect(carrierDetect), .transmitKey(transmitKey), .txOctet(txOctet),
  .txValid(txValid), .txReady(txReady), .txKind(txKind), .txFrameBody(txFrameBody));
